// >>> design/pmvt_defs.vh
/*
  Constants for the program memory, vector and table read block.
  Assumes it is included by design files that need the vector addresses
  and the table address layout.
*/
`ifndef PMVT_DEFS_VH
`define PMVT_DEFS_VH

// ============================================================
// Vectors
`define PMVT_VEC_RESET 13'h0000
`define PMVT_VEC_EXT 13'h0004
`define PMVT_VEC_TMR0 13'h0008
`define PMVT_VEC_TMR1 13'h000C
`define PMVT_VEC_TMR2 13'h0010
`define PMVT_VEC_TMR3 13'h0014

// ============================================================
// Table addressing
`define PMVT_LAST_PAGE_HI 5'h1F
`define PMVT_HI_PTR_W 5
`define PMVT_TBL_CYCLES 2'h2

`endif

// >>> design/pmvt_program_memory.v
/*
  Program memory with reset/interrupt vector selection and the table read
  path. Assumes the core supplies one-cycle requests on i_clock, loads the
  instruction store through the write port, and owns the stack depth count.
  Table read requests are single-cycle pulses, issued only while the port is idle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pmvt_defs.vh"

module pmvt_program_memory #(
  parameter ADDR_W = 13,
  parameter DATA_W = 16,
  parameter DEPTH = 8192,
  parameter HI_BITS = 8,
  parameter HAS_TMR2 = 1
) (
  input wire i_clock,
  input wire i_srst,
  // Fetch port.
  input wire [ADDR_W-1:0] i_fetch_addr,
  output reg [DATA_W-1:0] o_fetch_data,
  // Program load port.
  input wire i_load_we,
  input wire [ADDR_W-1:0] i_load_addr,
  input wire [DATA_W-1:0] i_load_data,
  // Interrupt sources; the external input is an asynchronous pin.
  input wire i_ext_int_n,
  input wire i_ext_int_en,
  input wire i_tmr0_ovf,
  input wire i_tmr0_en,
  input wire i_tmr1_ovf,
  input wire i_tmr1_en,
  input wire i_tmr2_ovf,
  input wire i_tmr2_en,
  input wire i_tmr3_ovf,
  input wire i_tmr3_en,
  input wire i_stack_full,
  input wire i_ack_taken,
  output reg o_branch,
  output reg [ADDR_W-1:0] o_branch_addr,
  output wire [4:0] o_int_pending,
  // Table read port.
  input wire [7:0] i_table_pointer_low,
  input wire [`PMVT_HI_PTR_W-1:0] i_table_pointer_high,
  input wire i_table_read_current_page,
  input wire i_table_read_last_page,
  input wire [7:0] i_operand_addr,
  output wire o_table_busy,
  output reg o_dm_we,
  output reg [7:0] o_dm_addr,
  output reg [7:0] o_dm_data,
  output reg [7:0] o_table_data_high_latch
);

  // ============================================================
  // Instruction store
  // The store has no reset: a word read before the core loads it is undefined,
  // so the core must fill the program and its tables before it starts fetching.
  // shared store
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] tbl_addr_q;
  reg [DATA_W-1:0] tbl_word_q;

  // Both read ports are registered, which lets the store map onto block memory.
  // A fetch from an address written on the same edge returns the old word.
  always @(posedge i_clock)
  begin
    if (i_load_we)
      mem[i_load_addr] <= i_load_data;
    o_fetch_data <= mem[i_fetch_addr];
    tbl_word_q <= mem[tbl_addr_q];
  end

  // ============================================================
  // Interrupt requests and vectors
  // Two flip-flops settle the asynchronous pin; the third only keeps the last
  // settled level, so that each falling edge raises exactly one event.
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  reg [4:0] pend_q;
  reg [4:0] pend_d;
  reg [4:0] evt;
  reg [4:0] ena;
  reg [4:0] grant;
  reg boot_q;
  integer k;

  assign o_int_pending = pend_q;

  always @*
  begin
    evt[0] = ext_s3_q & ~ext_s2_q;
    evt[1] = i_tmr0_ovf;
    evt[2] = i_tmr1_ovf;
    // timer 2 only on larger variants
    evt[3] = i_tmr2_ovf & (HAS_TMR2 != 0);
    evt[4] = i_tmr3_ovf;
    ena = {i_tmr3_en, i_tmr2_en, i_tmr1_en, i_tmr0_en, i_ext_int_en};
    // Highest priority is the lowest vector, so the first pending bit that is enabled wins.
    grant = 5'h00;
    for (k = 4; k >= 0; k = k - 1)
      if (pend_q[k] & ena[k])
        grant = 5'h00 | (5'h01 << k);
    // No grant in the cycle of a branch, so only one vector leaves at a time.
    // held while stack full
    if (i_stack_full | boot_q | o_branch)
      grant = 5'h00;
    // A grant that the core does not acknowledge leaves its flag set, so the
    // same vector is offered again once the branch pulse has passed.
    // New events win over the acknowledge clear.
    pend_d = (pend_q & ~(grant & {5{i_ack_taken}})) | evt;
  end

  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
      pend_q <= 5'h00;
      boot_q <= 1'b1;
      o_branch <= 1'b0;
      o_branch_addr <= `PMVT_VEC_RESET;
    end
    else
    begin
      ext_s1_q <= i_ext_int_n;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      pend_q <= pend_d;
      boot_q <= 1'b0;
      o_branch <= boot_q | (|grant);
      // The reset vector leaves on the first edge after reset, before any interrupt.
      // reset vector first
      if (boot_q)
        o_branch_addr <= `PMVT_VEC_RESET;
      else if (grant[0])
        o_branch_addr <= `PMVT_VEC_EXT;
      else if (grant[1])
        o_branch_addr <= `PMVT_VEC_TMR0;
      else if (grant[2])
        o_branch_addr <= `PMVT_VEC_TMR1;
      else if (grant[3])
        o_branch_addr <= `PMVT_VEC_TMR2;
      else if (grant[4])
        o_branch_addr <= `PMVT_VEC_TMR3;
    end
  end

  // ============================================================
  // Table read
  // A request that arrives while a read is in progress is dropped without
  // notice; the core must keep table reads at least three cycles apart.
  // Mask of the high-byte bits that have backing store; the rest read as zero.
  localparam [7:0] HI_MASK = (8'h01 << HI_BITS) - 8'h01;
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_DONE = 2'h2;
  reg [1:0] st_q;
  reg [7:0] opnd_q;

  assign o_table_busy = (st_q != ST_IDLE);

  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      st_q <= ST_IDLE;
      tbl_addr_q <= {ADDR_W{1'b0}};
      opnd_q <= 8'h00;
      o_dm_we <= 1'b0;
      o_dm_addr <= 8'h00;
      o_dm_data <= 8'h00;
      o_table_data_high_latch <= 8'h00;
    end
    else
    begin
      o_dm_we <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          // pointers already loaded by the program
          if (i_table_read_current_page | i_table_read_last_page)
          begin
            opnd_q <= i_operand_addr;
            st_q <= ST_READ;
            if (i_table_read_current_page)
              tbl_addr_q <= {i_table_pointer_high, i_table_pointer_low};
            else
              tbl_addr_q <= {`PMVT_LAST_PAGE_HI, i_table_pointer_low};
          end
        end
        ST_READ:
          st_q <= ST_DONE;
        ST_DONE:
        begin
          st_q <= ST_IDLE;
          // The low byte and the latch update on the same edge as the strobe.
          // low byte to data memory
          o_dm_we <= 1'b1;
          o_dm_addr <= opnd_q;
          o_dm_data <= tbl_word_q[7:0];
          o_table_data_high_latch <= tbl_word_q[15:8] & HI_MASK;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // pmvt_program_memory
`default_nettype wire

// >>> verification/pmvt_core_model.sv
/* Core model that loads the table pointers and issues table reads.
   Assumes go is driven at the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module pmvt_core_model (
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic i_last,
  input wire logic [12:0] i_addr,
  output logic [7:0] o_lo = 8'h00,
  output logic [4:0] o_hi = 5'h00,
  output logic o_cur = 1'b0,
  output logic o_lst = 1'b0
);
  logic go_q = 1'b0;
  always @(negedge i_clock)
  begin
    o_cur <= go_q && !i_last;
    o_lst <= go_q && i_last;
    go_q <= i_go;
    if (i_go)
      {o_hi, o_lo} <= i_addr;
  end
endmodule // pmvt_core_model
`default_nettype wire

// >>> verification/pmvt_program_memory_sva.sv
/* Assertions on the ports of the program memory block.
   Bound to every instance; one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module pmvt_program_memory_sva (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_table_read_current_page,
  input wire logic i_table_read_last_page,
  input wire logic [7:0] i_operand_addr,
  input wire logic i_stack_full,
  input wire logic o_table_busy,
  input wire logic o_dm_we,
  input wire logic [7:0] o_dm_addr,
  input wire logic o_branch,
  input wire logic [12:0] o_branch_addr,
  input wire logic [4:0] o_int_pending
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_req;
    (i_table_read_current_page || i_table_read_last_page) && !o_table_busy;
  endsequence
  // ==========
  // Properties
  chk_reset_vec: assert property (
    $fell(i_srst) |-> ##[0:1] (o_branch && o_branch_addr == 13'h0000)) else $error("no reset vector");
  chk_busy_span: assert property (s_req |=> o_table_busy[*2])
    else $error("busy too short");
  chk_write_lat: assert property (s_req |-> ##3 o_dm_we)
    else $error("write late");
  chk_we_pulse: assert property (o_dm_we |=> !o_dm_we)
    else $error("write too long");
  chk_dest_addr: assert property (
    o_dm_we |-> o_dm_addr == $past(i_operand_addr, 3)) else $error("wrong destination");
  chk_full_hold: assert property (
    o_branch && $past(o_int_pending) != 5'h00 |-> !$past(i_stack_full)) else $error("grant when full");
  chk_vec_range: assert property (
    o_branch |-> o_branch_addr[1:0] == 2'h0 && o_branch_addr < 13'h0018) else $error("bad vector");
  chk_branch_one: assert property (o_branch |=> !o_branch)
    else $error("branch too long");
endmodule // pmvt_program_memory_sva
bind pmvt_program_memory pmvt_program_memory_sva u_sva (.i_clock, .i_srst,
  .i_table_read_current_page, .i_table_read_last_page, .i_operand_addr, .i_stack_full,
  .o_table_busy, .o_dm_we, .o_dm_addr, .o_branch, .o_branch_addr, .o_int_pending);
`default_nettype wire

// >>> verification/testbench.sv
/* Self-checking bench for the program memory block.
   Assumes the core model issues table reads; fixed seed. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module testbench;
  logic i_clock = 1'b0, i_srst = 1'b1, go = 1'b0, last = 1'b0, we = 1'b0, ext_n = 1'b1;
  logic full = 1'b0, cur, lst, brn, dwe, busy;
  logic [31:0] lfsr = 32'hCBAF;
  int errors = 0, checked = 0, cyc = 0;
  logic [12:0] addr = 13'h0000, la = 13'h0000, fa = 13'h0000, badr, ba;
  logic [15:0] wd = 16'h0000, fd;
  logic [7:0] op = 8'h00, plo, dadr, dd, hl;
  logic [4:0] ovf = 5'h00, en = 5'h1F, phi, pend;
  pmvt_program_memory #(.HI_BITS(6)) DUT (.i_clock, .i_srst, .i_fetch_addr(fa),
    .o_fetch_data(fd), .i_load_we(we), .i_load_addr(la), .i_load_data(wd), .i_ext_int_n(ext_n),
    .i_ext_int_en(en[0]), .i_tmr0_ovf(ovf[1]), .i_tmr0_en(en[1]), .i_tmr1_ovf(ovf[2]),
    .i_tmr1_en(en[2]), .i_tmr2_ovf(ovf[3]), .i_tmr2_en(en[3]), .i_tmr3_ovf(ovf[4]),
    .i_tmr3_en(en[4]), .i_stack_full(full), .i_ack_taken(1'b1), .o_branch(brn),
    .o_branch_addr(badr), .o_int_pending(pend), .i_table_pointer_low(plo),
    .i_table_pointer_high(phi), .i_table_read_current_page(cur), .i_table_read_last_page(lst),
    .i_operand_addr(op), .o_table_busy(busy), .o_dm_we(dwe), .o_dm_addr(dadr), .o_dm_data(dd),
    .o_table_data_high_latch(hl));
  pmvt_core_model u_core (.i_clock, .i_go(go), .i_last(last), .i_addr(addr), .o_lo(plo),
    .o_hi(phi), .o_cur(cur), .o_lst(lst));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [12:0] taddr(input logic l, input logic [12:0] a);
    return l ? {5'h1F, a[7:0]} : a;
  endfunction
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Mode 1 blocks by a full stack, mode 2 by a cleared enable, then both are lifted.
  task automatic irq(input int k, input int m);
    logic seen;
    seen = 1'b0;
    ba = 13'h1FFF;
    full <= m == 1;
    en[k] <= m != 2;
    @(negedge i_clock);
    ovf[k] <= k > 0;
    ext_n <= k != 0;
    @(negedge i_clock);
    ovf <= 5'h00;
    repeat (12) @(negedge i_clock) if (brn) {seen, ba} = {1'b1, badr};
    `CHK("held", m != 0, pend[k] & !seen)
    {full, en} <= 6'h1F;
    repeat (12) @(negedge i_clock) if (brn) {seen, ba} = {1'b1, badr};
    `CHK("vector", 13'(4 * k + 4), ba)
    ext_n <= 1'b1;
  endtask
  task automatic tread(input logic l, input logic [12:0] a);
    logic [15:0] w;
    logic [7:0] o;
    {w, o} = {lfsr[15:0], lfsr[31:24]};
    lfsr = step(lfsr);
    @(negedge i_clock);
    {we, la, fa, wd, last, addr, op, go} <= {1'b1, taddr(l, a), taddr(l, a), w, l, a, o, 1'b1};
    @(negedge i_clock);
    {we, go} <= 2'b00;
    @(negedge i_clock);
    `CHK("fetch", w, fd)
    @(negedge i_clock);
    `CHK("busy", 1'b1, busy)
    repeat (7) @(negedge i_clock) if (dwe) break;
    `CHK("low byte", {1'b1, o, w[7:0]}, {dwe, dadr, dd})
    `CHK("high byte", {2'b00, w[13:8]}, hl)
  endtask
  initial forever #20 i_clock = ~i_clock;
  always @(posedge i_clock) if (++cyc == 5000)
  begin
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(negedge i_clock);
    i_srst <= 1'b0;
    @(negedge i_clock);
    `CHK("reset vector", 14'h2000, {brn, badr})
    for (int k = 0; k < 5; k++) irq(k, 0);
    irq(4, 1);
    irq(0, 2);
    irq(2, 2);
    tread(1'b0, 13'h1FFF);
    tread(1'b1, 13'h0000);
    repeat (40) tread(lfsr[8], lfsr[20:8]);
    i_srst <= 1'b1;
    repeat (2) @(negedge i_clock);
    i_srst <= 1'b0;
    @(negedge i_clock);
    `CHK("reset vector again", 14'h2000, {brn, badr})
    tread(1'b1, 13'h1E06);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
